// File: asmi_pkg.sv
// package of constants and types for the converter serial and channel interface
package asmi_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned RESULT_BITS     = 24;
  localparam logic [4:0]  LAST_EDGE       = 5'h18;
  localparam int unsigned CHAN_WORD_BITS  = 4;
  localparam logic [2:0]  CHAN_WORD_LAST  = 3'h4;
  localparam int unsigned CODE_BITS       = 3;
  localparam logic [2:0]  CHAN_RESET      = 3'h0;
  localparam logic [1:0]  SCK_DIV_HALF    = 2'h3;
  localparam int unsigned CONV_TIME_MS    = 133;
  localparam int unsigned CAL_TIME_MS     = 66;
  localparam int unsigned CONV_CYCLES     = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CAL_CYCLES      = CAL_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W           = 24;
  localparam logic [31:0] AXI_ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] AXI_ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] AXI_ADDR_RESULT = 32'h0000_0008;
  localparam logic [31:0] AXI_ADDR_CHAN   = 32'h0000_000C;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [3:0] {
    ST_CONVERT = 4'h1,
    ST_SLEEP   = 4'h2,
    ST_OUTPUT  = 4'h4,
    ST_CAL     = 4'h8
  } asmi_state_e;
endpackage

// File: asmi_top.sv
// converter serial interface: status flag, result shift-out, channel programming
// Function
// - select rising in data output aborts transfer, starts new conversion
// - channel strobe high while programming; its falling edge applies the channel
// - four-bit channel word shifted in on each rising multiplexer clock
// - first bit is enable, then three-bit channel code
// - enable bit zero keeps previous channel
// - clock mode chosen at each select falling edge; low sck means external
// - serial output released whenever select is high
// - select low outside output: serial output shows busy flag
// - conversion end enters sleep regardless of select
// - channel programmed in sleep takes effect at strobe fall
// - multiplexer clocks with strobe low leave channel unchanged
// - data or clock held low in sleep keeps channel
// - sleep holds result; wake on first rising sck with select low
// - output changes on falling sck; host samples on rising edges
// - 24th falling sck starts calibration and drives output high
// - calibration window after data output before converting
// - strobe tied to select does not alter channel
// - sck high at select fall or reset selects internal clock, device drives sck
// - internal sck is conversion clock divided by eight
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
module asmi_top
  import asmi_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES,
  parameter int unsigned CAL_CYC  = CAL_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        converter_select_n_i,
  input  wire logic        channel_select_strobe_i,
  input  wire logic        mux_clk_i,
  input  wire logic        mux_data_i,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic [7:0]       selected_input_output_o,
  input  wire logic [23:0] conv_data_i,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // channel code to one-hot input enable
  function automatic logic [7:0] chan_decode(input logic [2:0] code);
    logic [7:0] m;
    m = 8'h00;
    case (code)
      3'h0: m = 8'h01;
      3'h1: m = 8'h02;
      3'h2: m = 8'h04;
      3'h3: m = 8'h08;
      3'h4: m = 8'h10;
      3'h5: m = 8'h20;
      3'h6: m = 8'h40;
      default: m = 8'h80;
    endcase
    return m;
  endfunction

  // whole block state, registered as one word
  typedef struct packed {
    asmi_state_e      st;
    logic [CNT_W-1:0] cnt;
    logic [23:0]      shreg;
    logic [23:0]      result;
    logic [4:0]       edges;
    logic             sdo;
    logic             cs_d;
    logic             strobe_d;
    logic             sck_d;
    logic             mclk_d;
    logic             int_mode;
    logic             sck_int;
    logic [1:0]       div;
    logic [3:0]       chan_sh;
    logic [2:0]       chan_cnt;
    logic [2:0]       chan;
    logic             awd;
    logic             wd;
    logic [31:0]      awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } asmi_state_s;

  asmi_state_s s_r;
  asmi_state_s s_nxt;

  logic sck_now;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic strobe_fall;
  logic mclk_rise;

  // edges against last cycle's levels
  assign sck_now     = s_r.int_mode ? s_r.sck_int : sck_i;
  assign sck_rise    = sck_now & ~s_r.sck_d;
  assign sck_fall    = ~sck_now & s_r.sck_d;
  assign cs_rise     = converter_select_n_i & ~s_r.cs_d;
  assign cs_fall     = ~converter_select_n_i & s_r.cs_d;
  assign strobe_fall = ~channel_select_strobe_i & s_r.strobe_d;
  assign mclk_rise   = mux_clk_i & ~s_r.mclk_d;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.cs_d     = converter_select_n_i;
    s_nxt.strobe_d = channel_select_strobe_i;
    s_nxt.sck_d    = sck_now;
    s_nxt.mclk_d   = mux_clk_i;

    // clock mode picked at each select fall
    if (cs_fall) begin
      s_nxt.int_mode = sck_i;
      s_nxt.sck_int  = 1'b0;
      s_nxt.div      = 2'h0;
    end

    // internal shift clock toggles every four cycles: divide by eight
    if (s_r.int_mode && !converter_select_n_i && s_r.st == ST_OUTPUT) begin
      s_nxt.div = s_r.div + 2'h1;
      if (s_r.div == SCK_DIV_HALF) begin
        s_nxt.sck_int = ~s_r.sck_int;
      end
    end else if (s_r.int_mode && !converter_select_n_i && s_r.st == ST_SLEEP) begin
      s_nxt.sck_int = 1'b1;
    end

    // channel word shifts only while strobe high
    if (channel_select_strobe_i && mclk_rise) begin
      s_nxt.chan_sh = {s_r.chan_sh[2:0], mux_data_i};
      if (s_r.chan_cnt != CHAN_WORD_LAST) begin
        s_nxt.chan_cnt = s_r.chan_cnt + 3'h1;
      end
    end

    if (strobe_fall) begin
      if (s_r.chan_cnt == CHAN_WORD_LAST && s_r.chan_sh[3]) begin
        s_nxt.chan = s_r.chan_sh[2:0];
      end
      // incomplete word or enable low keeps channel
      s_nxt.chan_cnt = 3'h0;
      s_nxt.chan_sh  = 4'h0;
    end

    // conversion cycle sequencing
    case (s_r.st)
      ST_CONVERT: begin
        s_nxt.sdo = 1'b1;
        if (s_r.cnt == CNT_W'(CONV_CYC - 1)) begin
          s_nxt.st     = ST_SLEEP;
          s_nxt.result = conv_data_i;
          s_nxt.shreg  = conv_data_i;
          s_nxt.cnt    = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
      end
      ST_SLEEP: begin
        s_nxt.sdo = 1'b0;
        if (!converter_select_n_i && sck_rise) begin
          s_nxt.st    = ST_OUTPUT;
          s_nxt.edges = 5'h0;
        end
      end
      ST_OUTPUT: begin
        if (cs_rise) begin
          s_nxt.st  = ST_CAL;
          s_nxt.sdo = 1'b1;
          s_nxt.cnt = '0;
        end else if (sck_fall) begin
          s_nxt.edges = s_r.edges + 5'h1;
          if (s_r.edges + 5'h1 == LAST_EDGE) begin
            s_nxt.st  = ST_CAL;
            s_nxt.sdo = 1'b1;
            s_nxt.cnt = '0;
          end else begin
            s_nxt.sdo   = s_r.shreg[RESULT_BITS-1];
            s_nxt.shreg = {s_r.shreg[RESULT_BITS-2:0], 1'b0};
          end
        end
      end
      ST_CAL: begin
        s_nxt.sdo = 1'b1;
        if (s_r.cnt == CNT_W'(CAL_CYC - 1)) begin
          s_nxt.st  = ST_CONVERT;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
      end
      default: s_nxt.st = ST_CONVERT;
    endcase

    // bus slave write channels
    if (s_axi_awvalid && !s_r.awd && !s_r.bvalid) begin
      s_nxt.awd    = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.wd && !s_r.bvalid) begin
      s_nxt.wd    = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end

    if (s_r.awd && s_r.wd) begin
      s_nxt.awd    = 1'b0;
      s_nxt.wd     = 1'b0;
      s_nxt.bvalid = 1'b1;
      if (s_r.awaddr == AXI_ADDR_CTRL) begin
        s_nxt.bresp = RESP_OKAY;
        // lane zero carries the start bit
        if (s_r.wdata[0] && s_r.wstrb[0]) begin
          s_nxt.st  = ST_CAL;
          s_nxt.cnt = '0;
        end
      end else begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end

    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // bus slave read channel
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      if (s_axi_araddr == AXI_ADDR_STATUS) begin
        s_nxt.rdata = {27'h0, s_r.int_mode, s_r.st};
      end else if (s_axi_araddr == AXI_ADDR_RESULT) begin
        s_nxt.rdata = {8'h00, s_r.result};
      end else if (s_axi_araddr == AXI_ADDR_CHAN) begin
        s_nxt.rdata = {29'h0, s_r.chan};
      end else if (s_axi_araddr == AXI_ADDR_CTRL) begin
        s_nxt.rdata = 32'h0000_0000;
      end else begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = RESP_SLVERR;
      end
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  // async reset to the power-up state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r          <= '0;
      s_r.st       <= ST_CONVERT;
      s_r.sdo      <= 1'b1;
      s_r.cs_d     <= 1'b1;
      s_r.sck_d    <= 1'b1;
      s_r.int_mode <= 1'b1;
      s_r.sck_int  <= 1'b1;
      s_r.chan     <= CHAN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // pin outputs
  assign sdo_o    = s_r.sdo;
  assign sdo_oe_o = ~converter_select_n_i;
  assign sck_o    = s_r.sck_int;
  // pin stays released in the cycle the mode is picked, so a host driving it low wins
  assign sck_oe_o = s_r.int_mode & ~converter_select_n_i & ~s_r.cs_d;
  assign selected_input_output_o = chan_decode(s_r.chan);

  // bus outputs
  assign s_axi_awready = ~s_r.awd & ~s_r.bvalid;
  assign s_axi_wready  = ~s_r.wd & ~s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = ~s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

endmodule

// File: asmi_checker.sv
// port relation checks of the converter serial interface
`timescale 1ns/10ps
module asmi_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        converter_select_n_i,
  input wire logic        channel_select_strobe_i,
  input wire logic        sck_i,
  input wire logic        sck_oe_o,
  input wire logic        sdo_o,
  input wire logic        sdo_oe_o,
  input wire logic [7:0]  selected_input_output_o
);
  logic [4:0] falls_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) falls_r <= 5'h00;
    else if (converter_select_n_i) falls_r <= 5'h00;
    else if ($fell(sck_i)) falls_r <= falls_r + 5'h01;
  end
  property p_sdo_oe; sdo_oe_o == !converter_select_n_i; endproperty
  property p_chan_hold; $changed(selected_input_output_o) |-> !channel_select_strobe_i &&
    ($past(channel_select_strobe_i) || $past(channel_select_strobe_i, 2)
    || $past(channel_select_strobe_i, 3)); endproperty
  property p_onehot; $onehot(selected_input_output_o); endproperty
  property p_oe_sel; sck_oe_o |-> !converter_select_n_i; endproperty
  property p_oe_fall; $fell(converter_select_n_i) |-> !sck_oe_o; endproperty
  property p_ext; $fell(converter_select_n_i) && !sck_i
    |-> ##3 (!sck_oe_o || converter_select_n_i); endproperty
  property p_int; $fell(converter_select_n_i) && sck_i
    |-> ##3 (sck_oe_o || converter_select_n_i); endproperty
  property p_sdo_fall; $changed(sdo_o) && !converter_select_n_i
    && !$past(converter_select_n_i) && !sck_oe_o |-> !sck_i; endproperty
  property p_eoc24; falls_r == 5'h18 && $past(falls_r) == 5'h17 |-> ##[1:4] sdo_o;
  endproperty
  a_sdo_oe: assert property (p_sdo_oe) else $error("sdo enable wrong");
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  a_onehot: assert property (p_onehot) else $error("input select not one-hot");
  a_oe_sel: assert property (p_oe_sel) else $error("sck driven unselected");
  a_oe_fall: assert property (p_oe_fall) else $error("sck driven at mode pick");
  a_ext: assert property (p_ext) else $error("external mode not taken");
  a_int: assert property (p_int) else $error("internal mode not taken");
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved with sck high");
  a_eoc24: assert property (p_eoc24) else $error("no busy flag after frame");
  c_prog: cover property ($fell(channel_select_strobe_i));
  c_int: cover property ($rose(sck_oe_o));
  c_frame: cover property (falls_r == 5'h18);
endmodule
bind asmi_top asmi_checker i_asmi_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .converter_select_n_i(converter_select_n_i), .sck_i(sck_i), .sck_oe_o(sck_oe_o),
  .channel_select_strobe_i(channel_select_strobe_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .selected_input_output_o(selected_input_output_o));

// File: asmi_host.sv
// host controller model driving the converter serial pins
`timescale 1ns/10ps
module asmi_host (
  input  wire logic clk_i,
  output logic      sck_o,
  output logic      sck_oe_o,
  output logic      sel_n_o,
  output logic      strobe_o,
  output logic      data_o
);
  initial begin
    sck_o    = 1'b0;
    sck_oe_o = 1'b1;
    sel_n_o  = 1'b1;
    strobe_o = 1'b0;
    data_o   = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // sck stays low here while driven, so a select fall asks for external clock
  task automatic sel(input logic v);
    @(posedge clk_i);
    sel_n_o <= v;
    wait_n(4);
  endtask
  // sck stands still between pulses; sdo is sampled by the bench on the rise
  task automatic pulse();
    @(posedge clk_i);
    sck_o <= 1'b1;
    wait_n(4);
    sck_o <= 1'b0;
    wait_n(3);
  endtask
  task automatic frame(input int n);
    repeat (n) pulse();
  endtask
  task automatic word(input logic [3:0] w, input logic strb);
    @(posedge clk_i);
    strobe_o <= strb;
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk_i) data_o <= w[i];
      pulse();
    end
    @(posedge clk_i);
    strobe_o <= 1'b0;
    data_o   <= ~data_o;
    wait_n(4);
  endtask
  task automatic release_sck();
    @(posedge clk_i) sck_oe_o <= 1'b0;
  endtask
endmodule

// File: test_adc_serial_mux_interface.sv
// self-checking bench of the converter serial interface
`timescale 1ns/10ps
module test_adc_serial_mux_interface
  import asmi_pkg::*;
;
  logic        clk_i;
  logic        rst_n_i;
  logic [23:0] conv_data;
  logic [23:0] rnd = 24'h000005;
  logic [2:0]  code;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sck_o, sck_oe_o, sdo_o, sdo_oe_o, h_sck, h_oe, sel_n, strobe, mdata;
  logic [7:0]  sel_out;
  wire         sck_w = sck_oe_o ? sck_o : (h_oe ? h_sck : 1'b1);
  int          miscompares = 0;
  int          n_compared = 0;
  logic [31:0] exp_q[$];
  always #10 clk_i = ~clk_i;
  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  asmi_top #(.CONV_CYC(50), .CAL_CYC(20)) i_asmi_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .converter_select_n_i(sel_n), .channel_select_strobe_i(strobe), .mux_clk_i(sck_w),
    .mux_data_i(mdata), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .selected_input_output_o(sel_out), .conv_data_i(conv_data),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  asmi_host i_host (.clk_i(clk_i), .sck_o(h_sck), .sck_oe_o(h_oe), .sel_n_o(sel_n),
    .strobe_o(strobe), .data_o(mdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    check(s_axi_rresp, r);
    if (r === RESP_OKAY) check(s_axi_rdata, d);
    s_axi_rready <= 1'b0;
  endtask
  // the bench notes each bit it expects; this watcher takes them at each sck rise
  always @(posedge sck_w) if (exp_q.size() > 0) check(sdo_o, exp_q.pop_front());
  initial begin
    #(20 * 20000);
    miscompares++;
    test_done();
  end
  initial begin
    clk_i         = 1'b0;
    rst_n_i       = 1'b0;
    s_axi_awaddr  = 32'h0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'h0;
    s_axi_araddr  = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    conv_data     = rnd;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    i_host.sel(1'b0);
    check(sdo_o, 32'h1);
    i_host.wait_n(60);
    check(sdo_o, 32'h0);
    i_host.sel(1'b1);
    check(sdo_oe_o, 32'h0);
    rnd  = lfsr(rnd);
    code = rnd[2:0];
    i_host.word({1'b1, code}, 1'b1);
    check(sel_out, 8'h01 << code);
    i_host.word({1'b0, ~code}, 1'b1);
    check(sel_out, 8'h01 << code);
    i_host.word({1'b1, ~code}, 1'b0);
    check(sel_out, 8'h01 << code);
    i_host.word(4'h0, 1'b1);
    check(sel_out, 8'h01 << code);
    axi_rd(AXI_ADDR_STATUS, 32'h2, RESP_OKAY);
    axi_rd(AXI_ADDR_CHAN, {29'h0, code}, RESP_OKAY);
    axi_rd(AXI_ADDR_RESULT, {8'h00, conv_data}, RESP_OKAY);
    axi_rd(32'h0000_0010, 32'h0, RESP_SLVERR);
    axi_wr(32'h0000_0010, 32'h1, RESP_SLVERR);
    axi_wr(AXI_ADDR_CTRL, 32'h1, RESP_OKAY);
    axi_rd(AXI_ADDR_STATUS, 32'h8, RESP_OKAY);
    i_host.wait_n(80);
    exp_q.push_back(32'h0);
    for (int k = 23; k >= 1; k--) exp_q.push_back({31'h0, conv_data[k]});
    i_host.sel(1'b0);
    i_host.frame(24);
    i_host.wait_n(2);
    check(sdo_o, 32'h1);
    i_host.sel(1'b1);
    rnd = lfsr(rnd);
    conv_data <= rnd;
    i_host.wait_n(90);
    exp_q.push_back(32'h0);
    for (int k = 23; k >= 20; k--) exp_q.push_back({31'h0, conv_data[k]});
    i_host.sel(1'b0);
    i_host.frame(5);
    i_host.sel(1'b1);
    i_host.sel(1'b0);
    check(sdo_o, 32'h1);
    i_host.sel(1'b1);
    i_host.wait_n(90);
    i_host.release_sck();
    i_host.sel(1'b0);
    check(sck_oe_o, 32'h1);
    i_host.sel(1'b1);
    test_done();
  end
endmodule
